// ===== ltcp_panel.sv
// Top of the leak tester control panel logic.
`timescale 1ns/10ps
`default_nettype none
module ltcp_panel #(
  parameter int START_CYC = ltcp_pkg::START_SCREEN_CYC,
  parameter int TICK_LEN = ltcp_pkg::TICK_CYC,
  parameter int DEB_CYC = ltcp_pkg::DEBOUNCE_CYC
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // Keypad
  input wire ltcp_pkg::ltcp_keys_t keys,
  input wire logic [7:0] password_in,
  input wire logic password_load,
  // Retained state restored from nonvolatile store
  input wire ltcp_pkg::ltcp_mode_t saved_mode,
  input wire logic [4:0] saved_part,
  input wire logic restore,
  // Configuration and local part choice
  input wire ltcp_pkg::ltcp_sys_cfg_t cfg,
  input wire logic [4:0] local_part,
  input wire logic local_part_load,
  input wire logic part_fast_cycle_req,
  // External select inputs A..E
  input wire logic [4:0] ext_select,
  // Test events
  input wire logic test_start,
  input wire logic test_done,
  input wire logic test_pass,
  input wire logic test_fail,
  input wire logic test_gross,
  input wire logic abort,
  input wire logic cal_req,
  input wire logic [3:0] fault_code,
  input wire logic factory_clear,
  // Display
  output ltcp_pkg::ltcp_mode_t mode,
  output logic start_screen,
  output logic [3:0] status_code,
  output logic status_ready,
  output logic [3:0] param_index,
  output logic value_up,
  output logic value_down,
  output logic clear_counters_yes,
  output logic leak_visible,
  // Part selection and test control
  output logic [4:0] part_index,
  output logic [5:0] part_number,
  output logic cal_start,
  output logic fast_cycle,
  output ltcp_pkg::ltcp_relays_t relays,
  output logic [31:0] total_tests,
  output ltcp_pkg::ltcp_proto_t serial_protocol
);
  import ltcp_pkg::*;

  // ----------------------------------------------------------------
  // Start screen and restore
  // ----------------------------------------------------------------
  logic [31:0] start_cnt;
  logic [4:0] ext_clean;
  logic pw_sys_ok;
  logic pw_cal_ok;
  logic [31:0] tick_cnt;
  logic tick;
  logic [3:0] tenth;
  logic sec;
  logic [7:0] leak_s;
  logic [7:0] good_s;
  logic ext_en_d;

  // Hold the start screen for the full time, longer while up is held.
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      start_cnt <= '0;
      start_screen <= 1'b1;
    end else if (start_screen) begin
      if (keys.up) begin
        start_cnt <= '0;
      end else if (start_cnt >= 32'(START_CYC - 1)) begin
        start_screen <= 1'b0;
      end else begin
        start_cnt <= start_cnt + 32'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Operating mode
  // ----------------------------------------------------------------
  // The mode is reloaded from the saved copy, so a power cycle resumes.
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      mode <= LTCP_RUN;
    end else if (restore) begin
      mode <= saved_mode;
    end else if (keys.mode && !start_screen) begin
      unique case (mode)
        LTCP_RUN: mode <= LTCP_DATA;
        LTCP_DATA: mode <= LTCP_SETUP;
        LTCP_SETUP: mode <= LTCP_CAL;
        LTCP_CAL: mode <= LTCP_RUN;
      endcase
    end
  end

  // Fault code or ready on the top left, only in run or calibrate.
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      status_code <= FAULT_NONE;
      status_ready <= 1'b0;
    end else if (mode == LTCP_RUN || mode == LTCP_CAL) begin
      status_code <= fault_code;
      status_ready <= (fault_code == FAULT_NONE);
    end else begin
      status_code <= FAULT_NONE;
      status_ready <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Parameter scroll and passwords
  // ----------------------------------------------------------------
  // Each mode has its own last parameter; a mode change restarts at 0.
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      param_index <= '0;
    end else if (keys.mode || restore) begin
      param_index <= '0;
    end else if (keys.enter && !start_screen) begin
      unique case (mode)
        LTCP_RUN: param_index <= (param_index >= PARAM_LAST_RUN) ?
          4'h0 : param_index + 4'h1;
        LTCP_DATA: param_index <= (param_index >= PARAM_LAST_DATA) ?
          4'h0 : param_index + 4'h1;
        LTCP_SETUP: param_index <= (param_index >= PARAM_LAST_SETUP) ?
          4'h0 : param_index + 4'h1;
        LTCP_CAL: param_index <= (param_index >= PARAM_LAST_CAL) ?
          4'h0 : param_index + 4'h1;
      endcase
    end
  end

  // Passwords are forgotten on leaving the mode they unlocked, so a
  // left-open unit does not stay editable.
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      pw_sys_ok <= 1'b0;
      pw_cal_ok <= 1'b0;
    end else if (keys.mode || restore) begin
      pw_sys_ok <= 1'b0;
      pw_cal_ok <= 1'b0;
    end else if (password_load) begin
      pw_sys_ok <= (password_in == PW_SYSTEM);
      pw_cal_ok <= (password_in == PW_CAL);
    end
  end

  // Edit strobes only in setup mode once unlocked.
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      value_up <= 1'b0;
      value_down <= 1'b0;
    end else begin
      value_up <= keys.up && mode == LTCP_SETUP && pw_sys_ok;
      value_down <= keys.down && mode == LTCP_SETUP && pw_sys_ok;
    end
  end

  // Run mode: arrows only toggle the clear-counters choice.
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      clear_counters_yes <= 1'b0;
    end else if (mode != LTCP_RUN) begin
      clear_counters_yes <= 1'b0;
    end else if ((keys.up || keys.down) && !start_screen) begin
      clear_counters_yes <= !clear_counters_yes;
    end
  end

  // No operator path clears this count; only the factory input does.
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      total_tests <= '0;
    end else if (factory_clear) begin
      total_tests <= '0;
    end else if (test_start) begin
      total_tests <= total_tests + 32'h1;
    end
  end

  // ----------------------------------------------------------------
  // Part selection
  // ----------------------------------------------------------------
  ltcp_debounce #(
    .WIDTH(5),
    .STABLE_CYC(DEB_CYC)
  ) u_deb (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .raw(ext_select),
    .clean(ext_clean)
  );

  // The index addresses one of the stored setups; the store itself is
  // outside this block. Disabling external select leaves it untouched.
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      part_index <= PART_IDX_RST;
      ext_en_d <= 1'b0;
    end else begin
      ext_en_d <= cfg.ext_select_en;
      if (restore) begin
        part_index <= saved_part;
      end else if (cfg.ext_select_en) begin
        part_index <= ext_clean;
      end else if (local_part_load && !ext_en_d) begin
        part_index <= local_part;
      end
    end
  end

  // Displayed part number counts from one.
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      part_number <= 6'h01;
    end else begin
      part_number <= {1'b0, part_index} + 6'h01;
    end
  end

  // Calibration start, gated by protection password.
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      cal_start <= 1'b0;
      fast_cycle <= 1'b0;
    end else begin
      cal_start <= cal_req && mode == LTCP_CAL &&
        (!cfg.cal_protect || pw_cal_ok);
      fast_cycle <= cfg.fast_cycle_en && part_fast_cycle_req;
    end
  end

  // ----------------------------------------------------------------
  // Timers for leak display and good-part relay
  // ----------------------------------------------------------------
  // Both timers load at test_done, so the prescaler restarts there and a
  // set time runs its full length rather than up to a second short.
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      tick_cnt <= '0;
      tick <= 1'b0;
    end else if (test_done || tick_cnt >= 32'(TICK_LEN - 1)) begin
      tick_cnt <= '0;
      tick <= !test_done;
    end else begin
      tick_cnt <= tick_cnt + 32'h1;
      tick <= 1'b0;
    end
  end

  // Ten ticks of a tenth make one second.
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      tenth <= '0;
      sec <= 1'b0;
    end else begin
      sec <= tick && tenth == 4'h9 && !test_done;
      if (test_done) begin
        tenth <= '0;
      end else if (tick) begin
        tenth <= (tenth == 4'h9) ? 4'h0 : tenth + 4'h1;
      end
    end
  end

  // A zero time means off: hold until the next test starts.
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      leak_visible <= 1'b0;
      leak_s <= '0;
    end else if (test_start) begin
      leak_visible <= 1'b0;
    end else if (test_done) begin
      leak_visible <= 1'b1;
      leak_s <= cfg.leak_display_s;
    end else if (leak_visible && cfg.leak_display_s != VALUE_RST && sec) begin
      if (leak_s <= 8'h01) begin
        leak_visible <= 1'b0;
      end
      leak_s <= leak_s - 8'h01;
    end
  end

  // Relays: abort either drops all or freezes all.
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      relays <= '0;
      good_s <= '0;
    end else if (abort) begin
      if (!cfg.abort_output_hold) begin
        relays <= '0;
      end
    end else if (test_start) begin
      relays <= '0;
    end else if (test_done) begin
      relays.pass <= test_pass;
      relays.fail <= test_fail;
      relays.gross <= test_gross;
      good_s <= cfg.good_part_delay_s;
    end else if (relays.pass && cfg.good_part_delay_s != VALUE_RST && sec) begin
      if (good_s <= 8'h01) begin
        relays.pass <= 1'b0;
      end
      good_s <= good_s - 8'h01;
    end
  end

  // Serial protocol; out-of-range settings send nothing.
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      serial_protocol <= LTCP_PROTO_NONE;
    end else if (cfg.serial_protocol_select >= PROTO_MIN &&
                 cfg.serial_protocol_select <= PROTO_MAX) begin
      serial_protocol <= ltcp_proto_t'(cfg.serial_protocol_select);
    end else begin
      serial_protocol <= LTCP_PROTO_NONE;
    end
  end
endmodule : ltcp_panel
`default_nettype wire

// ===== ltcp_pkg.sv
// Package of constants and types for the leak tester control panel.
// Notes on behaviour
// - Start screen shows five seconds, held longer while up key is held.
// - Mode key steps run, data, setup, calibrate, then back to run.
// - After power returns the mode active at power-off is resumed.
// - Run or calibrate mode shows fault code or ready at top left.
// - Enter key steps to the next parameter of the current mode.
// - Up and down edit values only in setup mode after correct password.
// - System setup parameters need password 47 and apply to all parts.
// - In run mode up and down only toggle the clear-counters choice.
// - Total test counter is not operator resettable, factory clear only.
// - Setups for up to 32 parts live in battery-free nonvolatile store.
// - External select enabled overrides local part choice, else menu applies.
// - Disabling external select keeps last part until changed locally.
// - Select inputs weigh 1,2,4,8,16; part is one plus weighted sum.
// - With calibration protection on, calibration needs password 45.
// - Leak display off holds until next test; set time blanks; zero is off.
// - Abort switches outputs off unless abort output hold is on.
// - Pass output holds until next test or drops after the set delay.
// - Serial protocol 1 to 4 picks raw, scaled, custom or realtime.
// - Global fast-cycle off forbids any part from fast cycling.
package ltcp_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 40000000;
  localparam int START_SCREEN_S = 5;
  localparam int START_SCREEN_CYC = START_SCREEN_S * CLK_HZ;
  localparam int TICK_MS = 100;
  localparam int TICK_CYC = (TICK_MS * CLK_HZ) / 1000;
  localparam int DEBOUNCE_US = 1000;
  localparam int DEBOUNCE_CYC = (DEBOUNCE_US * (CLK_HZ / 1000000));

  // ----------------------------------------------------------------
  // Passwords and codes
  // ----------------------------------------------------------------
  localparam logic [7:0] PW_SYSTEM = 8'h2f;
  localparam logic [7:0] PW_CAL = 8'h2d;
  localparam int PARTS = 32;
  localparam logic [4:0] PART_IDX_RST = 5'h00;
  localparam logic [3:0] FAULT_NONE = 4'h0;
  localparam logic [2:0] PROTO_MIN = 3'h1;
  localparam logic [2:0] PROTO_MAX = 3'h4;
  localparam logic [3:0] PARAM_LAST_RUN = 4'h9;
  localparam logic [3:0] PARAM_LAST_DATA = 4'h3;
  localparam logic [3:0] PARAM_LAST_SETUP = 4'hf;
  localparam logic [3:0] PARAM_LAST_CAL = 4'h5;
  localparam logic [7:0] VALUE_RST = 8'h00;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    LTCP_RUN = 2'b00,
    LTCP_DATA = 2'b01,
    LTCP_SETUP = 2'b10,
    LTCP_CAL = 2'b11
  } ltcp_mode_t;

  typedef enum logic [2:0] {
    LTCP_PROTO_NONE = 3'b000,
    LTCP_PROTO_RAW = 3'b001,
    LTCP_PROTO_SCALED = 3'b010,
    LTCP_PROTO_CUSTOM = 3'b011,
    LTCP_PROTO_REALTIME = 3'b100
  } ltcp_proto_t;

  // One-cycle key press pulses from the front panel.
  typedef struct packed {
    logic up;
    logic down;
    logic mode;
    logic enter;
  } ltcp_keys_t;

  // System-wide settings that apply to every part setup alike.
  typedef struct packed {
    logic ext_select_en;
    logic cal_protect;
    logic abort_output_hold;
    logic fast_cycle_en;
    logic [7:0] leak_display_s;
    logic [7:0] good_part_delay_s;
    logic [2:0] serial_protocol_select;
  } ltcp_sys_cfg_t;

  // Outputs toward the fixture or PLC.
  typedef struct packed {
    logic pass;
    logic fail;
    logic gross;
  } ltcp_relays_t;

endpackage : ltcp_pkg

// ===== ltcp_debounce.sv
// Synchroniser and debouncer for the external part select inputs.
`timescale 1ns/10ps
`default_nettype none
module ltcp_debounce #(
  parameter int WIDTH = 5,
  parameter int STABLE_CYC = 40000
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // Raw and filtered pattern
  input wire logic [WIDTH-1:0] raw,
  output logic [WIDTH-1:0] clean
);
  import ltcp_pkg::*;

  logic [WIDTH-1:0] sync_a;
  logic [WIDTH-1:0] sync_b;
  logic [WIDTH-1:0] last;
  logic [31:0] stable;

  // Two flops; only the second stage is looked at by anything else.
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      sync_a <= '0;
      sync_b <= '0;
    end else begin
      sync_a <= raw;
      sync_b <= sync_a;
    end
  end

  // The whole pattern must hold still before it is passed on, so a
  // half-changed plug never decodes as a stray part.
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      last <= '0;
      stable <= '0;
      clean <= '0;
    end else begin
      last <= sync_b;
      if (sync_b != last) begin
        stable <= '0;
      end else if (stable < 32'(STABLE_CYC)) begin
        stable <= stable + 32'h1;
      end else begin
        clean <= last;
      end
    end
  end
endmodule : ltcp_debounce
`default_nettype wire

// ===== ltcp_plug_model.sv
// Fixture plug that wires a part number onto the select inputs.
`timescale 1ns/10ps
`default_nettype none
module ltcp_plug_model (
  // Part number the fixture stands for, 1 to 32
  input wire logic [5:0] part_sel,
  // Select inputs A..E
  output logic [4:0] ext_select
);
  // A weighs 1 up to E weighing 16, so part 1 leaves all lines off.
  // A plug has no clock, so the pattern changes the moment it is swapped.
  assign ext_select = 5'(part_sel - 6'h01);
endmodule : ltcp_plug_model
`default_nettype wire

// ===== ltcp_panel_properties.sv
// Concurrent checks on the ports of the control panel top.
`timescale 1ns/10ps
`default_nettype none
module ltcp_panel_chk
  import ltcp_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // Stimulus side
  input wire ltcp_pkg::ltcp_keys_t keys,
  input wire logic restore,
  input wire logic cal_req,
  input wire logic test_start,
  input wire logic test_done,
  input wire logic test_pass,
  input wire logic abort,
  input wire logic factory_clear,
  input wire ltcp_pkg::ltcp_sys_cfg_t cfg,
  // Design outputs
  input wire ltcp_pkg::ltcp_mode_t mode,
  input wire logic start_screen,
  input wire logic value_up,
  input wire logic value_down,
  input wire logic [4:0] part_index,
  input wire logic [5:0] part_number,
  input wire logic cal_start,
  input wire ltcp_pkg::ltcp_relays_t relays,
  input wire logic leak_visible,
  input wire logic [31:0] total_tests,
  input wire ltcp_pkg::ltcp_proto_t serial_protocol
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  // A passing verdict that nothing else overrides in the same cycle.
  sequence s_good_done;
    test_done && test_pass && !abort && !test_start;
  endsequence

  // --------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------
  // The start screen swallows keys, so only later presses step modes.
  a_mode_step: assert property (keys.mode && !start_screen
    && !restore |=> mode == ltcp_mode_t'($past(mode) + 2'h1))
    else $error("mode did not step");
  a_part_offset: assert property ($past(nrst)
    |-> part_number == {1'b0, $past(part_index)} + 6'h01)
    else $error("part number not index plus one");
  a_value_gate: assert property ((value_up || value_down)
    |-> $past(mode) == LTCP_SETUP && ($past(keys.up) || $past(keys.down)))
    else $error("value edit outside setup");
  a_cal_gate: assert property (cal_start
    |-> $past(cal_req) && $past(mode) == LTCP_CAL)
    else $error("calibration started without cause");
  a_abort_off: assert property (abort && !cfg.abort_output_hold
    |=> relays == 3'h0)
    else $error("outputs kept after abort");
  a_pass_shown: assert property (s_good_done
    |=> relays.pass && leak_visible)
    else $error("passed test not shown");
  a_total_count: assert property (!factory_clear && !abort
    && test_start |=> total_tests == $past(total_tests) + 32'h1)
    else $error("total counter missed a test");
  a_proto_map: assert property ($past(nrst) |-> serial_protocol ==
    (($past(cfg.serial_protocol_select) inside {[3'h1:3'h4]}) ?
    $past(cfg.serial_protocol_select) : 3'h0))
    else $error("protocol select wrong");
endmodule : ltcp_panel_chk

bind ltcp_panel ltcp_panel_chk i_chk (.*);
`default_nettype wire

// ===== ltcp_panel_tb.sv
// Self-checking testbench of the control panel top.
`timescale 1ns/10ps
`default_nettype none
module ltcp_panel_tb;
  import ltcp_pkg::*;
  localparam ltcp_keys_t K_UP = 4'h8;
  localparam ltcp_keys_t K_DN = 4'h4;
  localparam ltcp_keys_t K_MD = 4'h2;
  localparam ltcp_keys_t K_EN = 4'h1;
  logic clk_sys = 0, nrst = 0, password_load = 0, restore = 0;
  logic local_part_load = 0, part_fast_cycle_req = 0, test_start = 0;
  logic test_done = 0, test_pass = 0, test_fail = 0, test_gross = 0;
  logic abort = 0, cal_req = 0, factory_clear = 0;
  ltcp_keys_t keys = '0;
  ltcp_mode_t saved_mode = LTCP_RUN;
  ltcp_sys_cfg_t cfg = '0;
  logic [7:0] password_in = 8'h00;
  logic [4:0] saved_part = 5'h00, local_part = 5'h00, ext_select;
  logic [5:0] plug_part = 6'h01;
  logic [3:0] fault_code = 4'h0, status_code, param_index;
  ltcp_mode_t mode;
  logic start_screen, status_ready, value_up, value_down, cal_start;
  logic clear_counters_yes, leak_visible, fast_cycle;
  logic [4:0] part_index;
  logic [5:0] part_number;
  ltcp_relays_t relays;
  logic [31:0] total_tests;
  ltcp_proto_t serial_protocol;
  int error_cnt = 0, cmp_count = 0, cyc = 0;
  logic [5:0] plug_tbl [4] = '{6'h14, 6'h01, 6'h20, 6'h11};

  // Short counts keep the run brief; a second is 10 ticks of 4 cycles.
  ltcp_panel #(.START_CYC(20), .TICK_LEN(4), .DEB_CYC(4)) i_dut (.*);
  ltcp_plug_model i_plug (.part_sel(plug_part), .ext_select(ext_select));

  // 40 MHz clock.
  always #12.5 clk_sys = ~clk_sys;

  // --------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------
  task end_sim;
    if (error_cnt == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : end_sim

  // A hang must not hide behind a silent run.
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      error_cnt++;
      end_sim();
    end
  end

  task chk(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      error_cnt++;
      $display("wrong value at %0t: saw %0h want %0h", $time, s, e);
    end
  endtask : chk

  // Leaves the time step of the last edge so registered outputs settle.
  task step(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : step

  task press(input ltcp_keys_t k);
    @(posedge clk_sys) keys <= k;
    @(posedge clk_sys) keys <= '0;
    #1;
  endtask : press

  task pw(input logic [7:0] v);
    @(posedge clk_sys) begin
      password_in <= v;
      password_load <= 1'b1;
    end
    @(posedge clk_sys) password_load <= 1'b0;
    #1;
  endtask : pw

  // One-cycle event: 0 start, 1 done, 2 abort, 3 cal, 4 clear, 5 restore,
  // 6 local part load.
  task ev(input int w);
    @(posedge clk_sys) begin
      case (w)
        0: test_start <= 1'b1;
        1: test_done <= 1'b1;
        2: abort <= 1'b1;
        3: cal_req <= 1'b1;
        4: factory_clear <= 1'b1;
        5: restore <= 1'b1;
        default: local_part_load <= 1'b1;
      endcase
    end
    @(posedge clk_sys) begin
      {test_start, test_done, abort, cal_req} <= 4'h0;
      {factory_clear, restore, local_part_load} <= 3'h0;
    end
    #1;
  endtask : ev

  // --------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------
  task t_modes;
    press(K_MD);
    chk(mode, LTCP_RUN);
    step(30);
    chk(start_screen, 1'b0);
    press(K_MD);
    chk(mode, LTCP_DATA);
    press(K_EN);
    chk(param_index, 4'h1);
    for (int i = 2; i < 5; i++) begin
      press(K_MD);
      chk(mode, i % 4);
    end
    press(K_UP);
    chk(clear_counters_yes, 1'b1);
    chk(value_up, 1'b0);
    press(K_UP);
    chk(clear_counters_yes, 1'b0);
  endtask : t_modes

  task t_edit;
    press(K_MD);
    press(K_MD);
    press(K_UP);
    chk(value_up, 1'b0);
    pw(8'h2f);
    press(K_UP);
    chk(value_up, 1'b1);
    press(K_DN);
    chk(value_down, 1'b1);
  endtask : t_edit

  task t_cal;
    press(K_MD);
    @(posedge clk_sys) begin
      cfg.cal_protect <= 1'b1;
      fault_code <= 4'h3;
    end
    step(2);
    chk(status_code, 4'h3);
    chk(status_ready, 1'b0);
    @(posedge clk_sys) fault_code <= 4'h0;
    step(2);
    chk(status_ready, 1'b1);
    ev(3);
    chk(cal_start, 1'b0);
    pw(8'h2d);
    ev(3);
    chk(cal_start, 1'b1);
  endtask : t_cal

  task t_parts;
    @(posedge clk_sys) begin
      saved_mode <= LTCP_DATA;
      saved_part <= 5'h05;
      cfg.ext_select_en <= 1'b1;
      local_part <= 5'h03;
    end
    ev(5);
    chk(mode, LTCP_DATA);
    chk(part_index, 5'h05);
    foreach (plug_tbl[i]) begin
      @(posedge clk_sys) plug_part <= plug_tbl[i];
      step(16);
      chk(part_number, plug_tbl[i]);
    end
    // A one-cycle glitch and an ignored local load must never show up.
    @(posedge clk_sys) plug_part <= 6'h07;
    @(posedge clk_sys) plug_part <= 6'h11;
    ev(6);
    repeat (16) begin
      step(1);
      chk(part_number, 6'h11);
    end
    @(posedge clk_sys) cfg.ext_select_en <= 1'b0;
    step(4);
    chk(part_number, 6'h11);
    ev(6);
    chk(part_index, 5'h03);
    step(1);
    chk(part_number, 6'h04);
  endtask : t_parts

  task t_tests;
    ev(0);
    chk(total_tests, 32'h1);
    @(posedge clk_sys) test_pass <= 1'b1;
    ev(1);
    step(60);
    chk(relays.pass, 1'b1);
    chk(leak_visible, 1'b1);
    ev(0);
    chk(relays.pass, 1'b0);
    @(posedge clk_sys) begin
      cfg.good_part_delay_s <= 8'h01;
      cfg.leak_display_s <= 8'h01;
    end
    ev(1);
    step(30);
    chk(relays.pass, 1'b1);
    step(20);
    chk(relays.pass, 1'b0);
    chk(leak_visible, 1'b0);
    @(posedge clk_sys) begin
      {test_pass, test_fail} <= 2'b01;
      cfg.abort_output_hold <= 1'b1;
    end
    ev(1);
    ev(2);
    chk(relays.fail, 1'b1);
    @(posedge clk_sys) cfg.abort_output_hold <= 1'b0;
    ev(2);
    chk(relays, 3'h0);
    ev(4);
    chk(total_tests, 32'h0);
  endtask : t_tests

  task t_cfg;
    for (int i = 0; i < 8; i++) begin
      @(posedge clk_sys) cfg.serial_protocol_select <= 3'(i);
      step(2);
      chk(serial_protocol, (i > 0 && i < 5) ? i : 0);
    end
    @(posedge clk_sys) part_fast_cycle_req <= 1'b1;
    step(2);
    chk(fast_cycle, 1'b0);
    @(posedge clk_sys) cfg.fast_cycle_en <= 1'b1;
    step(2);
    chk(fast_cycle, 1'b1);
  endtask : t_cfg

  // Reset for 8 cycles, then the scenarios in a fixed order of modes.
  initial begin
    repeat (8) @(posedge clk_sys);
    nrst <= 1'b1;
    t_modes();
    t_edit();
    t_cal();
    t_parts();
    t_tests();
    t_cfg();
    end_sim();
  end
endmodule : ltcp_panel_tb
`default_nettype wire
